/* File: ldc_pkg.sv */
// package for the lcd drive control register block
package ldc_pkg;

	// register indices as printed (not all multiples of four); byte address is four times these
	localparam logic [7:0] LDC_IDX_DISPLAY_CONTROL   = 8'h1b;
	localparam logic [7:0] LDC_IDX_DUTY_CLOCK_SELECT = 8'h1c;
	localparam logic [7:0] LDC_IDX_SEGMENT_PIN_ASSIGN = 8'h1f;
	localparam logic [9:0] LDC_ADDR_DISPLAY_CONTROL   = {LDC_IDX_DISPLAY_CONTROL, 2'b00};
	localparam logic [9:0] LDC_ADDR_DUTY_CLOCK_SELECT = {LDC_IDX_DUTY_CLOCK_SELECT, 2'b00};
	localparam logic [9:0] LDC_ADDR_SEGMENT_PIN_ASSIGN = {LDC_IDX_SEGMENT_PIN_ASSIGN, 2'b00};
	// own status register, read only
	localparam logic [9:0] LDC_ADDR_STATUS            = 10'h080;

	// field positions
	localparam int LDC_BLANK_DISPLAY_BIT    = 0;
	localparam int LDC_POWER_SWITCH_BIT     = 1;
	localparam int LDC_LOWPOWER_DISPLAY_BIT = 2;
	localparam int LDC_DIVIDER_CONNECT_BIT  = 3;
	localparam int LDC_PORT6_SEGMENT_BIT    = 1;
	localparam int LDC_PORT7_SEGMENT_BIT    = 2;

	// reset values
	localparam logic [3:0] LDC_RST_DISPLAY_CONTROL   = 4'h0;
	localparam logic [3:0] LDC_RST_DUTY_CLOCK_SELECT = 4'h0;
	localparam logic [3:0] LDC_RST_SEGMENT_PIN_ASSIGN = 4'h0;

	// duty encodings
	localparam logic [1:0] LDC_DUTY_QUARTER = 2'h0;
	localparam logic [1:0] LDC_DUTY_THIRD   = 2'h1;
	localparam logic [1:0] LDC_DUTY_HALF    = 2'h2;
	localparam logic [1:0] LDC_DUTY_STATIC  = 2'h3;

	// clock source encodings
	localparam logic [1:0] LDC_SRC_SUB_DIV64    = 2'h0;
	localparam logic [1:0] LDC_SRC_OSC_DIV1024  = 2'h1;
	localparam logic [1:0] LDC_SRC_OSC_DIV8192  = 2'h2;
	localparam logic [1:0] LDC_SRC_TIMER_LINKED = 2'h3;

	// base divide ratios (ratio = base / duty, where duty = 1/n)
	localparam int LDC_DIV_SUB_DIV64   = 64;
	localparam int LDC_DIV_OSC_1024    = 1024;
	localparam int LDC_DIV_OSC_8192    = 8192;
	localparam int LDC_DIV_OSC_16384   = 16384;
	localparam int LDC_DIV_SUB_512     = 512;

	localparam logic [31:0] LDC_RDATA_ZERO = 32'h0000_0000;

	// decoded control set handed to the waveform side
	typedef struct packed {
		logic       display_on;
		logic       power_on;
		logic       lowpower_display;
		logic       divider_connect;
		logic [1:0] duty;
		logic [1:0] clk_src;
		logic       port6_seg;
		logic       port7_seg;
	} ldc_ctrl_t;

endpackage : ldc_pkg

/* File: ldc_divider.sv */
// frame clock divider: one pulse per n source ticks
`timescale 1ns/1ps
module ldc_divider
	import ldc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        tick,
	input  wire logic [14:0] ratio,
	output logic             pulse
);
	logic [14:0] count;
	wire         wrap = (count >= ratio - 15'd1);

	// restart when the ratio shrinks below the count so no long wrap occurs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 15'h0000;
			pulse <= 1'b0;
		end else begin
			pulse <= tick & wrap;
			if (tick) begin
				count <= wrap ? 15'h0000 : count + 15'd1;
			end
		end
	end
endmodule : ldc_divider

/* File: ldc_lcd_drive_control.sv */
// lcd drive control registers, apb slave and panel control outputs
//
// Function
// - control bit 1 switches the drive power switch off or on.
// - control bit 2 enables display in watch and subactive modes.
// - control bit 3 low connects divider resistor; high disconnects it.
// - duty/clock register is four write-only bits choosing duty and clock.
// - timer mode bit 3 low makes fourth source oscillator duty over 16384.
// - timer mode bit 3 high makes fourth source subclock duty over 512.
// - frame rate scales with duty; subclock source gives 512 or 128 hz.
// - segment register bit 1 turns port 6, bit 2 port 7 into segments.
// - reassignment works on four-pin groups covering segments 13 to 20; here the groups gate seg_out bits 0 to 7.
// - low-power display off grounds all pins and powers off in watch modes.
// - with power switch on the first drive level ties to supply.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module ldc_lcd_drive_control
	import ldc_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	input  wire logic [3:0]   pstrb,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         osc_tick,
	input  wire logic         subclk_tick,
	input  wire logic         timer_a_subclock_sel,
	input  wire logic         lowpower_mode,
	input  wire logic [31:0]  seg_ram_data,
	output logic [31:0]       seg_out,
	output logic              seg_ground,
	output logic              com_ground,
	output logic              power_switch_on,
	output logic              v1_tied_to_supply,
	output logic              divider_connected,
	output logic              port6_is_segment,
	output logic              port7_is_segment,
	output logic              frame_pulse,
	output ldc_ctrl_t         ctrl
);
	logic [3:0] display_control;
	logic [3:0] duty_clock_select;
	logic [3:0] segment_pin_assign;

	// pin-level inputs pass two flops before use
	// a slow tick is sampled many times per level, so no edge is lost
	logic [3:0] sync1;
	logic [3:0] sync2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= {timer_a_subclock_sel, lowpower_mode, subclk_tick, osc_tick};
			sync2 <= sync1;
		end
	end
	wire osc_lvl   = sync2[0];
	wire sub_lvl   = sync2[1];
	wire lp_mode   = sync2[2];
	wire tma_sub   = sync2[3];

	// rising-edge detect on the synchronised clock levels
	// reset value matches the idle tick level, so no false edge follows reset
	logic osc_q;
	logic sub_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_q <= 1'b0;
			sub_q <= 1'b0;
		end else begin
			osc_q <= osc_lvl;
			sub_q <= sub_lvl;
		end
	end
	wire osc_rise = osc_lvl & ~osc_q;
	wire sub_rise = sub_lvl & ~sub_q;

	// apb decode; writes take effect in the access phase, zero wait states
	wire [9:0] waddr        = paddr[11:2];
	wire       access       = psel & penable;
	// waddr is a word index, so it is held against the register indices
	wire       hit_ctrl     = (waddr == {2'b00, LDC_IDX_DISPLAY_CONTROL});
	wire       hit_duty     = (waddr == {2'b00, LDC_IDX_DUTY_CLOCK_SELECT});
	wire       hit_seg      = (waddr == {2'b00, LDC_IDX_SEGMENT_PIN_ASSIGN});
	wire       hit_stat     = (waddr == LDC_ADDR_STATUS);
	wire       mapped       = hit_ctrl | hit_duty | hit_seg | hit_stat;
	// write-only registers and the read-only status refuse the wrong direction
	wire       dir_ok       = pwrite ? (hit_ctrl | hit_duty | hit_seg) : hit_stat;
	// a write with byte lane 0 off carries no register bits and is ignored
	wire       wr_ok        = access & pwrite & dir_ok & pstrb[0];
	wire       wr_ctrl      = wr_ok & hit_ctrl;
	wire       wr_duty      = wr_ok & hit_duty;
	wire       wr_seg       = wr_ok & hit_seg;

	// zero wait states: the slave never stretches a transfer
	assign pready  = 1'b1;
	assign pslverr = access & ~(mapped & dir_ok);

	// register storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			display_control    <= LDC_RST_DISPLAY_CONTROL;
			duty_clock_select  <= LDC_RST_DUTY_CLOCK_SELECT;
			segment_pin_assign <= LDC_RST_SEGMENT_PIN_ASSIGN;
		end else begin
			if (wr_ctrl) display_control <= pwdata[3:0];
			if (wr_duty) duty_clock_select <= pwdata[3:0];
			// only bits 1 and 2 exist; others stay zero
			if (wr_seg) segment_pin_assign <= pwdata[3:0] & 4'h6;
		end
	end

	// field decode
	// control bit 3 is active low, unlike its neighbours
	wire       blank_n     = display_control[LDC_BLANK_DISPLAY_BIT];
	wire       pwr_bit     = display_control[LDC_POWER_SWITCH_BIT];
	wire       lp_disp     = display_control[LDC_LOWPOWER_DISPLAY_BIT];
	wire       div_conn    = ~display_control[LDC_DIVIDER_CONNECT_BIT];
	wire [1:0] duty_sel    = duty_clock_select[1:0];
	wire [1:0] clk_sel     = duty_clock_select[3:2];

	// in watch/subactive without low-power display everything is grounded
	// register fields are kept, so leaving watch mode restores the display
	wire       lp_off      = lp_mode & ~lp_disp;
	wire       pwr_eff     = pwr_bit & ~lp_off;

	// duty denominator n (duty = 1/n); static counts as 1
	logic [2:0] duty_n;
	always_comb begin
		unique case (duty_sel)
			LDC_DUTY_QUARTER: duty_n = 3'd4;
			LDC_DUTY_THIRD:   duty_n = 3'd3;
			LDC_DUTY_HALF:    duty_n = 3'd2;
			LDC_DUTY_STATIC:  duty_n = 3'd1;
		endcase
	end

	// each source gives one common phase per base_div input edges; a frame is n
	// phases, so the frame rate is fin / (base_div * n): static on the subclock
	// source runs at 32768 / 64 hz, quarter duty at a quarter of that
	logic [14:0] base_div;
	logic        use_sub;
	always_comb begin
		unique case (clk_sel)
			LDC_SRC_SUB_DIV64: begin
				base_div = 15'(LDC_DIV_SUB_DIV64);
				use_sub  = 1'b1;
			end
			LDC_SRC_OSC_DIV1024: begin
				base_div = 15'(LDC_DIV_OSC_1024);
				use_sub  = 1'b0;
			end
			LDC_SRC_OSC_DIV8192: begin
				base_div = 15'(LDC_DIV_OSC_8192);
				use_sub  = 1'b0;
			end
			LDC_SRC_TIMER_LINKED: begin
				base_div = tma_sub ? 15'(LDC_DIV_SUB_512)
				                   : 15'(LDC_DIV_OSC_16384);
				use_sub  = tma_sub;
			end
		endcase
	end

	// one divider serves every source; the select decides which edges it counts
	// the divider pulses once per common phase; ratios reach 16384 edges, hence
	// fifteen count bits
	wire        src_tick = use_sub ? sub_rise : osc_rise;
	wire [14:0] frame_ratio = base_div;
	logic       frame_raw;
	ldc_divider u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (src_tick),
		.ratio   (frame_ratio),
		.pulse   (frame_raw)
	);

	// common phase pulse: frame split into n phases, so frame rate = fin*duty/base
	logic [2:0] phase;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 3'h0;
		end else if (frame_raw) begin
			phase <= (phase >= duty_n - 3'd1) ? 3'h0 : phase + 3'd1;
		end
	end
	wire frame_done = frame_raw & (phase >= duty_n - 3'd1);

	// port groups of four pins gate seg_out bits 0-3 (port 6) and 4-7 (port 7)
	// pins of a group left as ports never show segment data
	wire p6_seg = segment_pin_assign[LDC_PORT6_SEGMENT_BIT];
	wire p7_seg = segment_pin_assign[LDC_PORT7_SEGMENT_BIT];
	wire [31:0] group_mask = {24'hff_ffff, {4{p7_seg}}, {4{p6_seg}}};

	// segment data: blank or grounded forces all off
	wire        seg_enable = blank_n & ~lp_off;
	wire [31:0] next_seg   = seg_enable ? (seg_ram_data & group_mask) : 32'h0000_0000;

	// segment drive: registered so the panel sees no decode glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_out <= 32'h0000_0000;
		end else begin
			seg_out <= next_seg;
		end
	end

	// pin grounding in watch/subactive modes; commons and segments move together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_ground <= 1'b0;
			com_ground <= 1'b0;
		end else begin
			seg_ground <= lp_off;
			com_ground <= lp_off;
		end
	end

	// power switch and first drive level share one source, so they never disagree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_switch_on   <= 1'b0;
			v1_tied_to_supply <= 1'b0;
		end else begin
			power_switch_on   <= pwr_eff;
			v1_tied_to_supply <= pwr_eff;
		end
	end

	// divider resistor and port group modes; divider reads 0 in reset, 1 right after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divider_connected <= 1'b0;
			port6_is_segment  <= 1'b0;
			port7_is_segment  <= 1'b0;
		end else begin
			divider_connected <= div_conn;
			port6_is_segment  <= p6_seg;
			port7_is_segment  <= p7_seg;
		end
	end

	// one-cycle frame marker
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_pulse <= 1'b0;
		end else begin
			frame_pulse <= frame_done;
		end
	end

	// decoded control bundle for the waveform generator
	// field order follows the struct declaration
	ldc_ctrl_t next_ctrl;
	assign next_ctrl = {seg_enable,   // display_on
	                    pwr_eff,      // power_on
	                    lp_disp,      // lowpower_display
	                    div_conn,     // divider_connect
	                    duty_sel,     // duty
	                    clk_sel,      // clk_src
	                    p6_seg,       // port6_seg
	                    p7_seg};      // port7_seg
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// status read: registers are write-only, so software sees state here;
	// sequencing the power switch around a drive voltage change is left to software
	// fields: [3:0] control, [7:4] duty/clock, [8] port 6, [9] port 7, [10] grounded
	wire [20:0] stat_pad    = 21'h00_0000;
	wire [31:0] status_word = {stat_pad, lp_off, p7_seg, p6_seg,
	                           duty_clock_select, display_control};

	// read data loads in the setup cycle so it stands through the access cycle;
	// any other setup or an idle bus clears it, so a refused read returns zero
	wire        rd_setup    = psel & ~penable;
	wire        rd_load     = ~psel | rd_setup;
	wire [31:0] next_prdata = (rd_setup & ~pwrite & hit_stat) ? status_word : LDC_RDATA_ZERO;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= LDC_RDATA_ZERO;
		end else if (rd_load) begin
			prdata <= next_prdata;
		end
	end
endmodule : ldc_lcd_drive_control

/* File: ldc_lcd_drive_control_sva.sv */
// assertion checker for the lcd drive control register block
`timescale 1ns/1ps
module ldc_lcd_drive_control_sva
	import ldc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        lowpower_mode,
	input wire logic [31:0] seg_out,
	input wire logic        seg_ground,
	input wire logic        com_ground,
	input wire logic        power_switch_on,
	input wire logic        v1_tied_to_supply,
	input wire logic        divider_connected,
	input wire logic        port6_is_segment,
	input wire logic        port7_is_segment,
	input wire ldc_ctrl_t   ctrl
);
	// access decode, mirrored from the bus so no design internals are needed
	wire logic wr    = psel && penable && pwrite && pstrb[0];
	wire logic rd    = psel && penable && !pwrite;
	wire logic wr_dc = wr && paddr == {2'b00, LDC_ADDR_DISPLAY_CONTROL};
	wire logic wr_dm = wr && paddr == {2'b00, LDC_ADDR_DUTY_CLOCK_SELECT};
	wire logic wr_sg = wr && paddr == {2'b00, LDC_ADDR_SEGMENT_PIN_ASSIGN};

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// writes show at the pins two edges later: one for the register, one for the output flop
	a_blank_segs_off: assert property (wr_dc && !pwdata[0] |->
		##2 seg_out == 32'h0000_0000) else $error("blank left segments on");
	a_power_follows: assert property (wr_dc && !lowpower_mode |->
		##2 power_switch_on == $past(pwdata[1], 2)) else $error("power switch wrong");
	a_lowpower_shown: assert property (lowpower_mode && ctrl.lowpower_display [*6] |->
		!seg_ground && !com_ground) else $error("display grounded while enabled");
	a_divider_inverse: assert property (wr_dc |->
		##2 divider_connected != $past(pwdata[3], 2)) else $error("divider polarity wrong");
	a_wo_refused: assert property (rd && (paddr == {2'b00, LDC_ADDR_DISPLAY_CONTROL} ||
		paddr == {2'b00, LDC_ADDR_DUTY_CLOCK_SELECT}) |-> pslverr && prdata == 32'h0000_0000)
		else $error("write-only read not refused");
	a_duty_source: assert property (wr_dm |-> ##2 ctrl.duty == $past(pwdata[1:0], 2) &&
		ctrl.clk_src == $past(pwdata[3:2], 2)) else $error("duty or source wrong");
	a_port_groups: assert property (wr_sg |-> ##2
		{port7_is_segment, port6_is_segment} == $past(pwdata[2:1], 2)) else $error("port group wrong");
	a_lowpower_ground: assert property (lowpower_mode && !ctrl.lowpower_display [*6] |->
		seg_ground && com_ground && !power_switch_on) else $error("low power pins not grounded");
	a_v1_with_power: assert property (v1_tied_to_supply == power_switch_on)
		else $error("first level not tied with power");
endmodule : ldc_lcd_drive_control_sva

bind ldc_lcd_drive_control ldc_lcd_drive_control_sva u_sva (.*);

/* File: ldc_panel_model.sv */
// far-side model: oscillator and subclock tick sources for the panel drive
`timescale 1ns/1ps
module ldc_panel_model (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      osc_tick,
	output logic      subclk_tick
);
	logic [1:0] phase = 2'b00;
	// sources scaled far above real rates and locked to pclk, so a frame spans exact cycles
	always @(posedge pclk) begin
		if (!presetn)
			phase <= 2'b00;
		else
			phase <= phase + 2'b01;
	end
	assign osc_tick    = phase[0];
	assign subclk_tick = phase[1];
endmodule : ldc_panel_model

/* File: tb_top.sv */
// self-checking bench for the lcd drive control register block
`timescale 1ns/1ps
module tb_top;
	import ldc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        timer_a_subclock_sel = 1'b0, lowpower_mode = 1'b0, snap = 1'b0, armed = 1'b0;
	logic        pready, pslverr, osc_tick, subclk_tick, seg_ground, com_ground, frame_pulse;
	logic        power_switch_on, v1_tied_to_supply, divider_connected;
	logic        port6_is_segment, port7_is_segment;
	logic [3:0]  pstrb = 4'hf, dc, sg;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, seg_ram_data = 32'h0000_0000, prdata, seg_out;
	ldc_ctrl_t   ctrl;
	logic [32:0] q_rsp[$];
	logic [32:0] rsp;
	logic [31:0] rd_exp = 32'h0000_0000;
	logic [38:0] q_out[$];
	int          q_frm[$];
	int          miscompares = 0, num_checks = 0, seed = 48106, cyc = 0, last = 0;
	logic [3:0]  d_tab[4] = '{4'h2, 4'h3, 4'h0, 4'h9}; // power off before drive change
	// duty/source words and frame spacing: ticks per frame times tick period in cycles
	logic [3:0]  f_dm[4] = '{4'h3, 4'h0, 4'h6, 4'hd};
	int          f_exp[4] = '{LDC_DIV_SUB_DIV64 * 4, LDC_DIV_SUB_DIV64 * 16,
	                         LDC_DIV_OSC_1024 * 4, LDC_DIV_SUB_512 * 12};
	localparam logic [11:0] A_DC = {2'b00, LDC_ADDR_DISPLAY_CONTROL};
	localparam logic [11:0] A_DM = {2'b00, LDC_ADDR_DUTY_CLOCK_SELECT};
	localparam logic [11:0] A_SG = {2'b00, LDC_ADDR_SEGMENT_PIN_ASSIGN};

	ldc_lcd_drive_control dut (.*);
	ldc_panel_model u_panel (.pclk(pclk), .presetn(presetn), .osc_tick(osc_tick),
		.subclk_tick(subclk_tick));

	always #20 pclk = ~pclk;

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	task automatic note(input string s);
		$display("test done: %s", s);
	endtask : note

	// one apb transfer; the bus stays selected so calls may follow back to back
	task automatic apb(input logic w, input logic [11:0] a, input logic [3:0] d, input logic e);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {28'($random(seed)), d};
		@(posedge pclk);
		penable <= 1'b1;
		q_rsp.push_back({e, rd_exp});
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
	endtask : apb

	// release the bus, let outputs settle, then hand the monitor a snapshot note
	task automatic settle(input int n, input logic [38:0] e);
		psel    <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge pclk);
		q_out.push_back(e);
		snap <= 1'b1;
		@(posedge pclk);
		snap <= 1'b0;
	endtask : settle

	task automatic pulse;
		do @(posedge pclk); while (frame_pulse !== 1'b1);
	endtask : pulse

	function automatic logic [38:0] exp_out(input logic [3:0] c, input logic [3:0] s, input logic lp);
		logic g;
		logic [31:0] m;
		g = lp && !c[2];
		m = {24'hff_ffff, {4{s[2]}}, {4{s[1]}}}; // port pins show no segments
		return {(c[0] && !g) ? (seg_ram_data & m) : 32'h0000_0000, c[1] && !g, c[1] && !g, !c[3],
			s[1], s[2], g, g};
	endfunction : exp_out

	// monitor: every result seen takes the oldest note of its kind
	always @(posedge pclk) begin
		cyc++;
		if (psel && penable && pready === 1'b1) begin
			rsp = q_rsp.pop_front();
			chk(pslverr, rsp[32]);
			if (!pwrite) chk(prdata, rsp[31:0]);
		end
		if (snap) chk({seg_out, power_switch_on, v1_tied_to_supply, divider_connected,
			port6_is_segment, port7_is_segment, seg_ground, com_ground}, q_out.pop_front());
		if (frame_pulse === 1'b1) begin
			if (armed) chk(cyc - last, q_frm.pop_front());
			last = cyc;
		end
	end

	initial begin
		seg_ram_data <= $random(seed);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		dc = 4'h0;
		sg = 4'h0;
		settle(1, exp_out(dc, sg, 1'b0));
		foreach (d_tab[i]) begin
			dc = d_tab[i];
			sg = 4'($random(seed));
			apb(1'b1, A_DC, dc, 1'b0);
			apb(1'b1, A_SG, sg, 1'b0);
			settle(3, exp_out(dc, sg, 1'b0));
		end
		note("control fields");
		rd_exp = {21'h00_0000, 1'b0, sg[2], sg[1], 4'h0, dc}; // status mirrors written state
		apb(1'b0, 12'h200, 4'h0, 1'b0);
		rd_exp = 32'h0000_0000;
		apb(1'b0, A_DC, 4'h0, 1'b1);
		apb(1'b0, A_DM, 4'h0, 1'b1);
		apb(1'b0, 12'h3f0, 4'h0, 1'b1);
		apb(1'b1, 12'h3f0, 4'h5, 1'b1);
		settle(3, exp_out(dc, sg, 1'b0));
		note("refusals");
		dc = 4'h3;
		apb(1'b1, A_DC, dc, 1'b0);
		settle(3, exp_out(dc, sg, 1'b0));
		lowpower_mode <= 1'b1;
		settle(8, exp_out(dc, sg, 1'b1));
		dc = 4'h7;
		apb(1'b1, A_DC, dc, 1'b0);
		settle(8, exp_out(dc, sg, 1'b1));
		lowpower_mode <= 1'b0;
		settle(8, exp_out(dc, sg, 1'b0));
		note("low power");
		for (int i = 0; i < 4; i++) begin
			timer_a_subclock_sel <= (i == 3);
			apb(1'b1, A_DM, f_dm[i], 1'b0);
			psel    <= 1'b0;
			penable <= 1'b0;
			repeat (2) pulse();
			q_frm.push_back(f_exp[i]);
			armed <= 1'b1;
			pulse();
			armed <= 1'b0;
		end
		note("frame rates");
		report_and_stop();
	end

	// watchdog: the whole run needs at most about 35k cycles
	initial begin
		repeat (80000) @(posedge pclk);
		miscompares++;
		report_and_stop();
	end
endmodule : tb_top
